// file: src/irdc_blinker.sv
// Millisecond time base and indicator pattern player.
// Assumes the pattern input comes from logic on the same clock.
`timescale 1ns/100ps
module irdc_blinker #(
  parameter int MS_CYCLES = irdc_pkg::MS_CYCLES
) (
  input wire logic   clk,
  input wire logic   reset_n,
  irdc_pat_if.player pat
);

  typedef struct packed {
    logic [15:0]            pre;
    logic                   tick;
    irdc_pkg::irdc_pat_type cur;
    logic [2:0]             idx;
    logic [15:0]            ms;
    logic                   done;
    logic                   led;
  } irdc_blink_state_type;

  irdc_blink_state_type s_ff;
  irdc_blink_state_type nxt_s;

  always_comb begin
    nxt_s = s_ff;
    nxt_s.tick = 1'b0;
    if (s_ff.pre == 16'(MS_CYCLES - 1)) begin
      nxt_s.pre = 16'h0000;
      nxt_s.tick = 1'b1;
    end else begin
      nxt_s.pre = s_ff.pre + 16'h0001;
    end
    // A new pattern always starts at its first phase.
    if (pat.pattern != s_ff.cur) begin
      nxt_s.cur = pat.pattern;
      nxt_s.idx = 3'h0;
      nxt_s.ms = 16'h0000;
      nxt_s.done = 1'b0;
    end else if (s_ff.tick && !s_ff.done) begin
      if (s_ff.ms + 16'h0001 >= irdc_pkg::phase_ms(s_ff.cur, s_ff.idx)) begin
        nxt_s.ms = 16'h0000;
        if (irdc_pkg::phase_ms(s_ff.cur, 3'(s_ff.idx + 3'h1)) == 16'h0000)
        begin
          // Cancel shows once; every other pattern repeats.
          if (s_ff.cur == irdc_pkg::PAT_CANCEL) begin
            nxt_s.done = 1'b1;
          end else begin
            nxt_s.idx = 3'h0;
          end
        end else begin
          nxt_s.idx = 3'(s_ff.idx + 3'h1);
        end
      end else begin
        nxt_s.ms = s_ff.ms + 16'h0001;
      end
    end
    nxt_s.led = (nxt_s.cur == irdc_pkg::PAT_SOLID) ||
                (nxt_s.cur != irdc_pkg::PAT_OFF &&
                 nxt_s.cur != irdc_pkg::PAT_SOLID &&
                 !nxt_s.done && !nxt_s.idx[0]);
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      s_ff <= '0;
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign pat.msTick = s_ff.tick;
  assign pat.led    = s_ff.led;

  property p_tick_single;
    @(posedge clk) disable iff (!reset_n)
      s_ff.tick |=> !s_ff.tick;
  endproperty
  a_tick_single: assert property (p_tick_single)
    else $error("Millisecond tick lasted more than one cycle.");

  property p_search_first_on;
    @(posedge clk) disable iff (!reset_n)
      (pat.pattern == irdc_pkg::PAT_SEARCH &&
       s_ff.cur != irdc_pkg::PAT_SEARCH) |=> pat.led ##1 pat.led;
  endproperty
  a_search_first_on: assert property (p_search_first_on)
    else $error("Search pattern did not start with the indicator on.");

endmodule

// file: src/irdc_pat_if.sv
// Carries the selected indicator pattern, the millisecond tick and the
// indicator level between the controller and the pattern player.
// Assumes both ends run on the same system clock.
`timescale 1ns/100ps
interface irdc_pat_if;
  irdc_pkg::irdc_pat_type pattern;
  logic                   msTick;
  logic                   led;
  modport player (input pattern, output msTick, output led);
  modport ctrl   (output pattern, input msTick, input led);
endinterface

// file: src/irdc_pkg.sv
// Constants, types and helper functions shared by the indicator,
// factory-reset and receiver duty-cycle logic.
// Assumes one 40 MHz system clock; all times are counted in milliseconds.
package irdc_pkg;

  localparam int CLK_HZ    = 40_000_000;
  localparam int MS_PER_S  = 1000;
  localparam int MS_CYCLES = CLK_HZ / MS_PER_S;

  // Indicator phase lengths in milliseconds.
  localparam logic [15:0] T100_MS = 16'h0064;
  localparam logic [15:0] T200_MS = 16'h00c8;
  localparam logic [15:0] T300_MS = 16'h012c;
  localparam logic [15:0] T400_MS = 16'h0190;
  localparam logic [15:0] T600_MS = 16'h0258;
  localparam logic [15:0] T900_MS = 16'h0384;
  localparam logic [15:0] TEND_MS = 16'h0000;

  // Bonding and reset-sequence timing in milliseconds.
  localparam logic [15:0] BRIEF_MIN_MS = 16'h0064;
  localparam logic [15:0] BRIEF_MAX_MS = 16'h07d0;
  localparam logic [15:0] SUSTAIN_MS   = 16'h07d0;
  localparam logic [15:0] HOLD_MS      = 16'h0bb8;
  localparam logic [15:0] FOUND_MS     = 16'h0bb8;
  localparam logic [15:0] RERR_MS      = 16'h0bb8;
  localparam logic [15:0] SEARCH_MS    = 16'h7530;
  localparam logic [15:0] TBL_ERR_MS   = 16'h2710;
  localparam logic [15:0] CANCEL_MS    = 16'h0190;
  localparam logic [2:0]  SEQ_PULSES   = 3'h4;

  // Receiver duty cycle.
  localparam logic [19:0] WAKE_MS   = 20'h00146;
  localparam logic [19:0] SEC_MS    = 20'h003e8;
  localparam logic [3:0]  PWR_RESET = 4'h0;

  typedef enum logic [3:0] {
    PAT_OFF    = 4'h0,
    PAT_SOLID  = 4'h1,
    PAT_SEARCH = 4'h3,
    PAT_FOUND  = 4'h2,
    PAT_ERR    = 4'h6,
    PAT_RERR   = 4'h7,
    PAT_CANCEL = 4'h5,
    PAT_ACK    = 4'h4
  } irdc_pat_type;

  typedef logic [5:0][15:0] irdc_phase_type;

  // Phase lists, first entry in the low slot; a zero length ends the list.
  localparam irdc_phase_type SEARCH_PH =
    {TEND_MS, TEND_MS, TEND_MS, TEND_MS, T900_MS, T100_MS};
  localparam irdc_phase_type FOUND_PH =
    {TEND_MS, TEND_MS, TEND_MS, TEND_MS, T100_MS, T400_MS};
  localparam irdc_phase_type ERR_PH =
    {TEND_MS, TEND_MS, TEND_MS, TEND_MS, T100_MS, T100_MS};
  localparam irdc_phase_type RERR_PH =
    {TEND_MS, TEND_MS, T300_MS, T100_MS, T100_MS, T100_MS};
  localparam irdc_phase_type CANCEL_PH =
    {TEND_MS, TEND_MS, TEND_MS, T100_MS, T200_MS, T100_MS};
  localparam irdc_phase_type ACK_PH =
    {T100_MS, T200_MS, T100_MS, T200_MS, T100_MS, T600_MS};

  // Thresholds of the power-level ratio scaled to 0..255.
  localparam logic [14:0][7:0] PWR_TAB = {
    8'hff, 8'hfa, 8'he8, 8'hd4, 8'hc2, 8'had, 8'h9c, 8'h87,
    8'h73, 8'h61, 8'h4d, 8'h3b, 8'h26, 8'h14, 8'h00};

  function automatic logic [15:0] phase_ms(irdc_pat_type p,
                                           logic [2:0]   i);
    irdc_phase_type t;
    case (p)
      PAT_SEARCH: t = SEARCH_PH;
      PAT_FOUND:  t = FOUND_PH;
      PAT_ERR:    t = ERR_PH;
      PAT_RERR:   t = RERR_PH;
      PAT_CANCEL: t = CANCEL_PH;
      PAT_ACK:    t = ACK_PH;
      default:    t = '0;
    endcase
    return (i > 3'h5) ? TEND_MS : t[i];
  endfunction

  function automatic logic [3:0] power_step(logic [7:0] code);
    logic [3:0] n;
    n = 4'h0;
    for (int i = 1; i < 15; i++) begin
      if (code >= PWR_TAB[i]) begin
        n = 4'(i);
      end
    end
    return n;
  endfunction

  function automatic logic [19:0] secs_to_ms(logic [7:0] s);
    return 20'(20'(s) * SEC_MS);
  endfunction

endpackage

// file: src/irdc_top.sv
// Indicator pattern control, factory-reset sequence detection, output
// power sampling and receiver duty cycling for a remote-control module.
// Assumes the radio signals are on clk; the bonding input is a pin.
//
// What this block does
// - Indicator solid on while transmitting, in the idle state only.
// - Indicator solid on while receiving, in the idle state only.
// - Search blinks 100 ms on, 900 ms off.
// - Found blinks 400/100 ms, at least three seconds.
// - Local table full blinks 100/100 ms.
// - Remote full blinks 100/100/100/300 ms.
// - Cancel shows 100 on, 200 off, 100 on.
// - Reset acknowledge shows six-phase 600/100/200 pattern.
// - Extended cancel holds indicator on until release.
// - Four brief pulses then long hold requests reset.
// - Each brief phase lasts 0.1 to 2 seconds.
// - Acknowledge until release, then reinitialise configuration.
// - Reset erases bonded table, keeps local address.
// - Timing mismatch shows cancel, no reset or bond.
// - Power step sampled once at power-up.
// - Duty cycle wakes, listens, stays on with data.
// - Sleep interval is seconds between turn-on points.
// - Wake window 326 ms, standby is remainder.
// - Stay awake after activity, then full sleep.
// - Brief request searches 30 s, held searches while high.
// - Second request during search cancels bonding.
`timescale 1ns/100ps
module irdc_top #(
  parameter int MS_CYCLES = irdc_pkg::MS_CYCLES
) (
  input  wire logic       clk,
  input  wire logic       reset_n,
  input  wire logic       bondRequestIn,
  input  wire logic       txActive,
  input  wire logic       rxActive,
  input  wire logic       txDone,
  input  wire logic       rxValid,
  input  wire logic       bondFound,
  input  wire logic       localTableFull,
  input  wire logic       remoteTableFull,
  input  wire logic       dutyEnable,
  input  wire logic [7:0] sleepIntervalSeconds,
  input  wire logic [7:0] stayAwakeSeconds,
  input  wire logic [7:0] powerLevelIn,
  output logic            activityIndicatorOut,
  output logic            bondSearching,
  output logic            tableClear,
  output logic            configInit,
  output logic [3:0]      powerStep,
  output logic            receiverOn
);

  typedef enum logic [3:0] {
    ST_IDLE   = 4'h0,
    ST_SEARCH = 4'h1,
    ST_FOUND  = 4'h3,
    ST_SEQ    = 4'h2,
    ST_ACK    = 4'h6,
    ST_EXTCAN = 4'h7,
    ST_CANCEL = 4'h5,
    ST_TBLERR = 4'h4,
    ST_RERR   = 4'hc
  } irdc_bond_type;

  typedef enum logic [1:0] {
    DU_SLEEP = 2'h0,
    DU_WAKE  = 2'h1,
    DU_KEEP  = 2'h3
  } irdc_duty_type;

  typedef struct packed {
    logic          sync1;
    logic          sync2;
    logic          prevReq;
    irdc_bond_type st;
    logic [15:0]   edgeMs;
    logic [15:0]   stateMs;
    logic [2:0]    pulses;
    logic          firstOk;
    logic          sustained;
    logic          clear;
    logic          sampled;
    logic [3:0]    power;
    irdc_duty_type duty;
    logic [19:0]   dutyMs;
    logic [19:0]   dutyLimit;
  } irdc_top_state_type;

  irdc_top_state_type s_ff;
  irdc_top_state_type nxt_s;
  irdc_pat_if         patIf ();

  logic        tick;
  logic        req;
  logic        rise;
  logic        fall;
  logic        okLen;
  logic        activity;
  logic [19:0] intervalMs;
  logic [19:0] stayMs;

  irdc_blinker #(
    .MS_CYCLES (MS_CYCLES)
  ) u_blinker (
    .clk     (clk),
    .reset_n (reset_n),
    .pat     (patIf.player)
  );

  assign tick       = patIf.msTick;
  assign req        = s_ff.sync2;
  assign rise       = s_ff.sync2 && !s_ff.prevReq;
  assign fall       = !s_ff.sync2 && s_ff.prevReq;
  assign okLen      = s_ff.edgeMs >= irdc_pkg::BRIEF_MIN_MS &&
                      s_ff.edgeMs <= irdc_pkg::BRIEF_MAX_MS;
  assign activity   = rxValid || txDone;
  assign intervalMs = irdc_pkg::secs_to_ms(sleepIntervalSeconds);
  assign stayMs     = irdc_pkg::secs_to_ms(stayAwakeSeconds);

  always_comb begin
    nxt_s = s_ff;
    nxt_s.sync1 = bondRequestIn;
    nxt_s.sync2 = s_ff.sync1;
    nxt_s.prevReq = s_ff.sync2;
    nxt_s.clear = 1'b0;
    if (tick && s_ff.edgeMs != 16'hffff) begin
      nxt_s.edgeMs = s_ff.edgeMs + 16'h0001;
    end
    if (tick && s_ff.stateMs != 16'hffff) begin
      nxt_s.stateMs = s_ff.stateMs + 16'h0001;
    end
    if (rise || fall) begin
      nxt_s.edgeMs = 16'h0000;
    end
    case (s_ff.st)
      ST_IDLE: begin
        if (rise) begin
          nxt_s.stateMs = 16'h0000;
          nxt_s.firstOk = 1'b0;
          nxt_s.sustained = 1'b0;
          nxt_s.st = localTableFull ? ST_TBLERR : ST_SEARCH;
        end
      end
      ST_SEARCH: begin
        if (bondFound) begin
          nxt_s.st = ST_FOUND;
          nxt_s.stateMs = 16'h0000;
        end else if (remoteTableFull) begin
          nxt_s.st = ST_RERR;
          nxt_s.stateMs = 16'h0000;
        end else if (rise) begin
          // A second press may also be the start of a reset sequence.
          nxt_s.pulses = 3'h1;
          nxt_s.st = (s_ff.firstOk && okLen) ? ST_SEQ : ST_CANCEL;
          nxt_s.stateMs = 16'h0000;
        end else if (fall) begin
          nxt_s.firstOk = okLen;
          if (s_ff.sustained) begin
            nxt_s.st = ST_IDLE;
          end
        end else if (req && s_ff.edgeMs >= irdc_pkg::SUSTAIN_MS) begin
          nxt_s.sustained = 1'b1;
        end else if (!s_ff.sustained &&
                     s_ff.stateMs >= irdc_pkg::SEARCH_MS) begin
          nxt_s.st = ST_IDLE;
        end
      end
      ST_FOUND: begin
        if (!req && s_ff.stateMs >= irdc_pkg::FOUND_MS) begin
          nxt_s.st = ST_IDLE;
        end
      end
      ST_TBLERR: begin
        if (s_ff.stateMs >= irdc_pkg::TBL_ERR_MS) begin
          nxt_s.st = ST_IDLE;
        end
      end
      ST_RERR: begin
        if (s_ff.stateMs >= irdc_pkg::RERR_MS) begin
          nxt_s.st = ST_IDLE;
        end
      end
      ST_CANCEL: begin
        if (s_ff.stateMs >= irdc_pkg::CANCEL_MS) begin
          nxt_s.st = ST_IDLE;
        end
      end
      ST_SEQ: begin
        nxt_s.stateMs = 16'h0000;
        if (rise) begin
          if (!okLen) begin
            nxt_s.st = ST_EXTCAN;
          end
        end else if (fall) begin
          if (s_ff.pulses != irdc_pkg::SEQ_PULSES && okLen) begin
            nxt_s.pulses = 3'(s_ff.pulses + 3'h1);
          end else begin
            nxt_s.st = ST_CANCEL;
          end
        end else if (req) begin
          if (s_ff.pulses == irdc_pkg::SEQ_PULSES) begin
            if (s_ff.edgeMs >= irdc_pkg::HOLD_MS) begin
              nxt_s.st = ST_ACK;
            end
          end else if (s_ff.edgeMs > irdc_pkg::BRIEF_MAX_MS) begin
            nxt_s.st = ST_EXTCAN;
          end
        end else if (s_ff.edgeMs > irdc_pkg::BRIEF_MAX_MS) begin
          nxt_s.st = ST_CANCEL;
        end
      end
      ST_ACK: begin
        if (!req) begin
          nxt_s.clear = 1'b1;
          nxt_s.st = ST_IDLE;
        end
      end
      ST_EXTCAN: begin
        if (!req) begin
          nxt_s.st = ST_IDLE;
        end
      end
      default: begin
        nxt_s.st = ST_IDLE;
      end
    endcase

    // The level is caught once, on the first edge after reset release.
    if (!s_ff.sampled) begin
      nxt_s.sampled = 1'b1;
      nxt_s.power = irdc_pkg::power_step(powerLevelIn);
    end

    if (tick) begin
      nxt_s.dutyMs = s_ff.dutyMs + 20'h00001;
    end
    if (!dutyEnable) begin
      nxt_s.duty = DU_WAKE;
      nxt_s.dutyMs = 20'h00000;
    end else begin
      case (s_ff.duty)
        DU_WAKE: begin
          if (activity) begin
            nxt_s.duty = DU_KEEP;
            nxt_s.dutyMs = 20'h00000;
          end else if (tick &&
                       s_ff.dutyMs >= irdc_pkg::WAKE_MS - 20'h00001)
          begin
            nxt_s.duty = DU_SLEEP;
            nxt_s.dutyMs = 20'h00000;
            // An interval shorter than the window leaves a token sleep.
            nxt_s.dutyLimit = (intervalMs > irdc_pkg::WAKE_MS) ?
                              intervalMs - irdc_pkg::WAKE_MS : 20'h00001;
          end
        end
        DU_KEEP: begin
          if (activity) begin
            nxt_s.dutyMs = 20'h00000;
          end else if (s_ff.dutyMs >= stayMs) begin
            nxt_s.duty = DU_SLEEP;
            nxt_s.dutyMs = 20'h00000;
            nxt_s.dutyLimit = intervalMs;
          end
        end
        DU_SLEEP: begin
          if (s_ff.dutyMs >= s_ff.dutyLimit) begin
            nxt_s.duty = DU_WAKE;
            nxt_s.dutyMs = 20'h00000;
          end
        end
        default: begin
          nxt_s.duty = DU_WAKE;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      s_ff <= '0;
      s_ff.st <= ST_IDLE;
      s_ff.duty <= DU_WAKE;
      s_ff.power <= irdc_pkg::PWR_RESET;
    end else begin
      s_ff <= nxt_s;
    end
  end

  always_comb begin
    case (s_ff.st)
      ST_IDLE:   patIf.pattern = (txActive || rxActive) ?
                                 irdc_pkg::PAT_SOLID : irdc_pkg::PAT_OFF;
      ST_SEARCH: patIf.pattern = irdc_pkg::PAT_SEARCH;
      ST_FOUND:  patIf.pattern = irdc_pkg::PAT_FOUND;
      ST_TBLERR: patIf.pattern = irdc_pkg::PAT_ERR;
      ST_RERR:   patIf.pattern = irdc_pkg::PAT_RERR;
      ST_CANCEL: patIf.pattern = irdc_pkg::PAT_CANCEL;
      ST_ACK:    patIf.pattern = irdc_pkg::PAT_ACK;
      ST_EXTCAN: patIf.pattern = irdc_pkg::PAT_SOLID;
      default:   patIf.pattern = irdc_pkg::PAT_OFF;
    endcase
  end

  assign activityIndicatorOut = patIf.led;
  assign bondSearching        = s_ff.st == ST_SEARCH;
  assign tableClear           = s_ff.clear;
  assign configInit           = s_ff.clear;
  assign powerStep            = s_ff.power;
  assign receiverOn           = !dutyEnable || s_ff.duty != DU_SLEEP;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  property p_tx_solid;
    (s_ff.st == ST_IDLE && txActive) |=> activityIndicatorOut;
  endproperty
  a_tx_solid: assert property (p_tx_solid)
    else $error("Indicator not on while transmitting.");

  property p_rx_solid;
    (s_ff.st == ST_IDLE && rxActive && !txActive) |=> activityIndicatorOut;
  endproperty
  a_rx_solid: assert property (p_rx_solid)
    else $error("Indicator not on while receiving.");

  property p_second_press;
    (s_ff.st == ST_SEARCH && rise && !bondFound && !remoteTableFull)
      |=> (s_ff.st == ST_SEQ || s_ff.st == ST_CANCEL);
  endproperty
  a_second_press: assert property (p_second_press)
    else $error("Second bonding request did not cancel the search.");

  property p_clear_after_ack;
    tableClear |-> ($past(s_ff.st) == ST_ACK && !$past(req) &&
                    configInit && s_ff.st == ST_IDLE);
  endproperty
  a_clear_after_ack: assert property (p_clear_after_ack)
    else $error("Table clear without acknowledged reset and release.");

  property p_extcan_on;
    (s_ff.st == ST_EXTCAN && req) |=> activityIndicatorOut;
  endproperty
  a_extcan_on: assert property (p_extcan_on)
    else $error("Extended cancel did not hold the indicator on.");

  property p_wake_end;
    (dutyEnable && s_ff.duty == DU_WAKE && !activity && tick &&
     s_ff.dutyMs == irdc_pkg::WAKE_MS - 20'h00001)
      |=> (s_ff.duty == DU_SLEEP && !receiverOn);
  endproperty
  a_wake_end: assert property (p_wake_end)
    else $error("Wake window did not end after 326 ms.");

  property p_keep_restart;
    (dutyEnable && s_ff.duty == DU_KEEP && activity)
      |=> (s_ff.dutyMs == 20'h00000 && receiverOn);
  endproperty
  a_keep_restart: assert property (p_keep_restart)
    else $error("Activity did not restart the stay-awake time.");

  property p_power_once;
    $past(s_ff.sampled) |-> $stable(powerStep);
  endproperty
  a_power_once: assert property (p_power_once)
    else $error("Power step changed after power-up.");

  property p_search_timeout;
    (s_ff.st == ST_SEARCH && !s_ff.sustained && !rise && !fall &&
     !bondFound && !remoteTableFull && !req &&
     s_ff.stateMs >= irdc_pkg::SEARCH_MS) |=> s_ff.st == ST_IDLE;
  endproperty
  a_search_timeout: assert property (p_search_timeout)
    else $error("Brief bonding search did not end after 30 s.");

  c_reset_seq: cover property (s_ff.st == ST_SEQ ##1 s_ff.st == ST_ACK);
  c_found:     cover property (s_ff.st == ST_SEARCH ##1 s_ff.st == ST_FOUND);
  c_extcan:    cover property (s_ff.st == ST_EXTCAN ##1 s_ff.st == ST_IDLE);
  c_sleep:     cover property (s_ff.duty == DU_KEEP ##1 !receiverOn);

endmodule

// file: tb/irdc_button.sv
// User side model: the push button pin and the indicator LED.
// Assumes tasks are called from the falling clock edge.
`timescale 1ns/100ps
module irdc_button #(
  parameter int MSC = 2
) (
  input wire logic clk,
  input wire logic led,
  output logic     btn
);
  int   ledRises;
  logic ledQ;
  initial begin
    btn = 1'b0;
    ledRises = 0;
    ledQ = 1'b0;
  end
  // Counts LED turn-on edges as a person would see them.
  always @(posedge clk) begin
    if (led === 1'b1 && ledQ !== 1'b1) begin
      ledRises++;
    end
    ledQ <= led;
  end
  task automatic waitMs(input int n);
    repeat (n * MSC) @(negedge clk);
  endtask
  task automatic setBtn(input logic v);
    btn = v;
  endtask
  // A valid sequence keeps every phase in 0.1 to 2 s.
  task automatic press(input int hi, input int lo);
    btn = 1'b1;
    waitMs(hi);
    btn = 1'b0;
    waitMs(lo);
  endtask
endmodule

// file: tb/irdc_top_test.sv
// Self-checking bench for the indicator, reset and duty logic.
// Assumes MS_CYCLES is shortened so one millisecond is two clocks.
`timescale 1ns/100ps
module irdc_top_test;
  localparam int MSC = 2;
  logic       clk, reset_n, btn, txActive, rxActive, txDone, rxValid;
  logic       bondFound, localTableFull, remoteTableFull, dutyEnable;
  logic [7:0] sleepSec, staySec, pwrIn;
  logic       led, searching, tableClear, configInit, receiverOn;
  logic [3:0] powerStep;
  int         n_errors, n_compared, nClr, cycles;

  irdc_top #(.MS_CYCLES(MSC)) dut_u (
    .clk(clk), .reset_n(reset_n), .bondRequestIn(btn),
    .txActive(txActive), .rxActive(rxActive), .txDone(txDone),
    .rxValid(rxValid), .bondFound(bondFound),
    .localTableFull(localTableFull), .remoteTableFull(remoteTableFull),
    .dutyEnable(dutyEnable), .sleepIntervalSeconds(sleepSec),
    .stayAwakeSeconds(staySec), .powerLevelIn(pwrIn),
    .activityIndicatorOut(led), .bondSearching(searching),
    .tableClear(tableClear), .configInit(configInit),
    .powerStep(powerStep), .receiverOn(receiverOn));

  irdc_button #(.MSC(MSC)) user_u (.clk(clk), .led(led), .btn(btn));

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  task automatic chk(input logic [3:0] seen, input logic [3:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_errors++;
      $display("BAD %0t got %h want %h", $time, seen, exp);
    end
  endtask

  task automatic print_verdict();
    if (n_errors == 0 && n_compared > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic ms(input int n);
    repeat (n * MSC) @(negedge clk);
  endtask

  // A run that hangs is cut short at 100000 cycles, about 15000 above the planned length.
  always @(posedge clk) begin
    cycles++;
    if (tableClear === 1'b1) begin
      nClr++;
      chk(configInit, 4'h1);
    end
    if (cycles == 100000) begin
      n_errors++;
      print_verdict();
    end
  end

  task automatic t_power();
    chk(powerStep, 4'h6);
    pwrIn = 8'hff;
    ms(2);
    chk(powerStep, 4'h6);
  endtask

  task automatic t_txrx();
    txActive = 1'b1;
    ms(1);
    chk(led, 4'h1);
    txActive = 1'b0;
    rxActive = 1'b1;
    ms(1);
    chk(led, 4'h1);
    rxActive = 1'b0;
    ms(5);
    chk(led, 4'h0);
  endtask

  task automatic t_search();
    user_u.setBtn(1'b1);
    ms(50);
    chk(led, 4'h1);
    ms(450);
    chk(led, 4'h0);
    ms(550);
    chk(led, 4'h1);
    ms(1450);
    chk(searching, 4'h1);
    user_u.setBtn(1'b0);
    ms(20);
    chk(searching, 4'h0);
    ms(200);
  endtask

  task automatic t_found();
    user_u.press(300, 900);
    bondFound = 1'b1;
    @(negedge clk);
    bondFound = 1'b0;
    ms(50);
    chk(led, 4'h1);
    ms(370);
    txActive = 1'b1;
    ms(30);
    chk(led, 4'h0);
    txActive = 1'b0;
    ms(100);
    chk(led, 4'h1);
    chk(searching, 4'h0);
    ms(3050);
    chk(led, 4'h0);
  endtask

  task automatic t_cancel();
    user_u.press(300, 2500);
    user_u.ledRises = 0;
    user_u.press(300, 700);
    chk(4'(user_u.ledRises), 4'h2);
    chk(searching, 4'h0);
    chk(led, 4'h0);
  endtask

  task automatic t_reset();
    repeat (4) user_u.press(300, 500);
    user_u.setBtn(1'b1);
    ms(3200);
    chk(led, 4'h1);
    ms(450);
    chk(led, 4'h0);
    chk(4'(nClr), 4'h0);
    ms(350);
    user_u.setBtn(1'b0);
    ms(20);
    chk(4'(nClr), 4'h1);
  endtask

  task automatic t_mismatch();
    user_u.press(300, 500);
    user_u.setBtn(1'b1);
    ms(2400);
    chk(led, 4'h1);
    ms(200);
    user_u.setBtn(1'b0);
    ms(1000);
    chk(4'(nClr), 4'h1);
    chk(searching, 4'h0);
  endtask

  task automatic t_full();
    localTableFull = 1'b1;
    user_u.setBtn(1'b1);
    ms(50);
    chk(led, 4'h1);
    ms(100);
    chk(led, 4'h0);
    ms(100);
    chk(led, 4'h1);
    user_u.setBtn(1'b0);
    localTableFull = 1'b0;
    ms(10300);
    chk(led, 4'h0);
  endtask

  // The remote full pattern must win over the search it interrupts.
  task automatic t_remote();
    user_u.setBtn(1'b1);
    ms(20);
    chk(searching, 4'h1);
    remoteTableFull = 1'b1;
    @(negedge clk);
    remoteTableFull = 1'b0;
    user_u.setBtn(1'b0);
    ms(50);
    chk(led, 4'h1);
    ms(100);
    chk(led, 4'h0);
    ms(100);
    chk(led, 4'h1);
    ms(200);
    chk(led, 4'h0);
    ms(200);
    chk(led, 4'h1);
    ms(2500);
    chk(led, 4'h0);
    chk(searching, 4'h0);
  endtask

  // Awake 326 ms of each second; activity stretches the wake by one
  // second of quiet, then a full interval of sleep follows.
  task automatic t_duty();
    dutyEnable = 1'b1;
    ms(100);
    chk(receiverOn, 4'h1);
    ms(300);
    chk(receiverOn, 4'h0);
    ms(700);
    chk(receiverOn, 4'h1);
    ms(100);
    rxValid = 1'b1;
    @(negedge clk);
    rxValid = 1'b0;
    ms(200);
    chk(receiverOn, 4'h1);
    ms(700);
    chk(receiverOn, 4'h1);
    ms(200);
    chk(receiverOn, 4'h0);
    ms(1000);
    chk(receiverOn, 4'h1);
    // Two-second interval, no stay-awake time: sleep follows at once.
    sleepSec = 8'h02;
    staySec = 8'h00;
    txDone = 1'b1;
    @(negedge clk);
    txDone = 1'b0;
    ms(100);
    chk(receiverOn, 4'h0);
    ms(1800);
    chk(receiverOn, 4'h0);
    ms(200);
    chk(receiverOn, 4'h1);
    ms(400);
    chk(receiverOn, 4'h0);
  endtask

  initial begin
    {reset_n, txActive, rxActive, txDone, rxValid} = 5'h00;
    {bondFound, localTableFull, remoteTableFull, dutyEnable} = 4'h0;
    sleepSec = 8'h01;
    staySec = 8'h01;
    pwrIn = 8'h80;
    n_errors = 0;
    n_compared = 0;
    nClr = 0;
    cycles = 0;
    repeat (10) @(negedge clk);
    reset_n = 1'b1;
    ms(2);
    t_power();
    t_txrx();
    t_search();
    t_found();
    t_cancel();
    t_reset();
    t_mismatch();
    t_full();
    t_remote();
    t_duty();
    print_verdict();
  end
endmodule
